// File: test/bcr_regs_checker.sv
// checker for the board control register bank
// assumes it is bound onto bcr_regs, single ref_clk domain
`timescale 1ns/1ps

module bcr_regs_checker
  import bcr_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               rstn,
  input wire bcr_pkg::bcr_bus_s  bus,
  input wire logic [7:0]         rdata,
  input wire logic               local_transfer_clock_locked,
  input wire logic               remote_transfer_clock_locked,
  input wire logic [31:0]        word_in,
  input wire logic [31:0]        word_out,
  input wire logic [1:0]         word_chan,
  input wire bcr_pkg::bcr_ctrl_s ctrl
);
  // ---------------------------------------------
  // shadows of the registers, from bus writes
  // ---------------------------------------------
  logic       cmd, hsw, bsw;
  logic [3:0] chen, lsb;
  logic [1:0] pp;
  logic [2:0] stab;
  wire  [1:0] pins = {remote_transfer_clock_locked, local_transfer_clock_locked};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {cmd, hsw, bsw, chen, lsb} <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        8'h00: cmd <= bus.wdata[3];
        8'h0f: {hsw, bsw} <= {bus.wdata[3], bus.wdata[0]};
        8'h10: chen <= bus.wdata[3:0];
        8'h16: lsb <= bus.wdata[3:0];
        default: ;
      endcase
    end
  end
  // lock reads judged only once pins sat still past the sync lag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {pp, stab} <= '0;
    end else begin
      pp <= pins;
      stab <= (pp != pins) ? 3'h0 : stab + {2'h0, stab != 3'h7};
    end
  end
  function automatic logic [31:0] order(input logic [31:0] w, input logic h, b, l);
    logic [31:0] t;
    t = b ? {w[23:16], w[31:24], w[7:0], w[15:8]} : w;
    t = h ? {t[15:0], t[31:16]} : t;
    if (l) t = {<<{t}};
    return t;
  endfunction
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_dma_gate; 1 |=> ctrl.dma_allow == ($past(chen) & {4{$past(cmd)}}); endproperty
  a_dma_gate: assert property (p_dma_gate)
    else $error("dma allow wrong");
  property p_flush; 1 |=> ctrl.fifo_flush == !$past(cmd) && ctrl.flag_clear == !$past(cmd);
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush or flag clear wrong");
  property p_chan_reset; 1 |=> ctrl.chan_reset == ~($past(chen) & {4{$past(cmd)}}); endproperty
  a_chan_reset: assert property (p_chan_reset)
    else $error("channel reset wrong");
  property p_lock; bus.rd && bus.addr == 8'h03 && stab > 3'h3 |=> rdata == {6'h0, $past(pins)};
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock status wrong");
  property p_cfg_rd; bus.rd && bus.addr == 8'h0f |=> rdata == {4'h0, $past(hsw), 2'h0, $past(bsw)};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("config readback wrong");
  property p_cmd_rd; bus.rd && bus.addr == 8'h00 |=> rdata == {4'h0, $past(cmd), 3'h0}; endproperty
  a_cmd_rd: assert property (p_cmd_rd)
    else $error("command readback wrong");
  property p_rd_idle; !bus.rd |=> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_word; 1 |=> word_out == order($past(word_in), $past(hsw), $past(bsw),
    $past(lsb[word_chan])); endproperty
  a_word: assert property (p_word)
    else $error("word order wrong");
endmodule

bind bcr_regs bcr_regs_checker u_bcr_regs_checker (.ref_clk(ref_clk), .rstn(rstn), .bus(bus),
  .rdata(rdata), .local_transfer_clock_locked(local_transfer_clock_locked),
  .remote_transfer_clock_locked(remote_transfer_clock_locked), .word_in(word_in),
  .word_out(word_out), .word_chan(word_chan), .ctrl(ctrl));

// File: test/bcr_regs_tb_top.sv
// self-checking bench for the board control register bank
// assumes bcr_regs with its checker bound in from the checker file
`timescale 1ns/1ps

module bcr_regs_tb_top;
  import bcr_pkg::*;
  // ---------------------------------------------
  // stimulus and checks
  // ---------------------------------------------
  logic        ref_clk, rstn, loc, rem, ovf, unf, irq;
  bcr_bus_s    bus;
  bcr_ctrl_s   ctrl;
  logic [7:0]  rdata, v;
  logic [31:0] word_in, word_out;
  logic [1:0]  word_chan;
  int          fails, tests_run;

  bcr_regs u_bcr_regs (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .local_transfer_clock_locked(loc), .remote_transfer_clock_locked(rem),
    .fifo_overflow(ovf), .fifo_underflow(unf), .word_in(word_in), .word_out(word_out),
    .word_chan(word_chan), .ctrl(ctrl), .irq(irq));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, rdata});
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [31:0] expect_word(input logic [31:0] w, input logic [2:0] m);
    logic [31:0] t;
    t = m[0] ? {w[23:16], w[31:24], w[7:0], w[15:8]} : w;
    if (m[1]) t = {t[15:0], t[31:16]};
    if (m[2]) t = {<<{t}};
    return t;
  endfunction
  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // under two hundred cycles expected; generous margin
  initial begin
    #50000;
    fails++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    bus = '0;
    {loc, rem, ovf, unf, word_chan} = '0;
    word_in = '0;
    fails = 0;
    tests_run = 0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    #1 chk("reset ctrl", 6'h3f, {ctrl.chan_reset, ctrl.fifo_flush, ctrl.flag_clear});
    wr(8'h05, 8'hff);
    for (int i = 0; i < 9; i++) rd(8'h80 >> i, 8'h00);
    loc <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(8'h03, 8'h01);
    {loc, rem} <= 2'b01;
    repeat (5) @(posedge ref_clk);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h02);
    rd(8'h20, 8'h03);
    unf <= 1'b1;
    wr(8'h20, 8'h0f);
    repeat (4) @(posedge ref_clk);
    rd(8'h20, 8'h00);
    wr(8'h10, 8'h05);
    settle();
    chk("dma off", 4'h0, ctrl.dma_allow);
    wr(8'h00, 8'h08);
    settle();
    chk("dma on", 10'h168, ctrl);
    rd(8'h00, 8'h08);
    ovf <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(8'h20, 8'h04);
    wr(8'h21, 8'h00);
    settle();
    chk("irq masked", 1'b0, irq);
    wr(8'h21, 8'h0f);
    rd(8'h21, 8'h0f);
    settle();
    chk("irq unmasked", 1'b1, irq);
    wr(8'h20, 8'h04);
    rd(8'h20, 8'h00);
    settle();
    chk("irq clear", 1'b0, irq);
    for (int m = 0; m < 8; m++) begin
      v = m[2] ? 8'h05 : 8'h0a;
      wr(8'h0f, {4'h0, m[1], 2'h0, m[0]});
      wr(8'h16, v);
      word_chan <= m[1:0];
      word_in <= 32'h01a3_c5e7;
      settle();
      chk("word", expect_word(32'h01a3_c5e7, {v[m[1:0]], m[1:0]}), word_out);
      rd(8'h0f, {4'h0, m[1], 2'h0, m[0]});
      rd(8'h16, v);
    end
    wr(8'h00, 8'h00);
    settle();
    chk("cmd off", 5'h01, {ctrl.dma_allow, ctrl.fifo_flush});
    tally_and_finish();
  end
endmodule

// File: verilog/bcr_pkg.sv
// package for the board control register bank
// assumes a single ref_clk domain and a plain strobe register port
package bcr_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int WORD_W = 32;
  localparam int NCH    = 4;

  localparam logic [7:0] OFF_GLOBAL_COMMAND    = 8'h00;
  localparam logic [7:0] OFF_CLOCK_LOCK_STATUS = 8'h03;
  localparam logic [7:0] OFF_WORD_ORDER_CONFIG = 8'h0f;
  localparam logic [7:0] OFF_CHANNEL_ENABLE    = 8'h10;
  localparam logic [7:0] OFF_LSB_FIRST         = 8'h16;
  localparam logic [7:0] OFF_IRQ_STATUS        = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK          = 8'h21;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int BIT_CMD_ENABLE     = 3;
  localparam int BIT_REMOTE_LOCK    = 1;
  localparam int BIT_LOCAL_LOCK     = 0;
  localparam int BIT_HALF_WORD_SWAP = 3;
  localparam int BIT_BYTE_PAIR_SWAP = 0;

  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [7:0] RD_UNMAP = 8'h00;

  // irq status bits: 0 local lock change, 1 remote lock change,
  // 2 fifo overflow, 3 fifo underflow
  localparam int IRQ_W        = 4;
  localparam int IRQ_LOCAL    = 0;
  localparam int IRQ_REMOTE   = 1;
  localparam int IRQ_OVERFLOW = 2;
  localparam int IRQ_UNDERFL  = 3;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bcr_bus_s;

  typedef struct packed {
    logic [NCH-1:0] dma_allow;
    logic [NCH-1:0] chan_reset;
    logic           fifo_flush;
    logic           flag_clear;
  } bcr_ctrl_s;

endpackage

// File: verilog/bcr_regs.sv
// board control register bank with data word ordering
// assumes lock and fifo flags arrive asynchronously; bus is on ref_clk
//
// What this block does
// - dma allowed per channel only with global enable and channel enable both set
// - global enable clear resets all channels, flushes fifos, clears flow flags
// - status bit 1 reports remote side transfer clock locked
// - status bit 0 reports local side transfer clock locked
// - config bit 3 swaps 16-bit halves of each 32-bit word
// - config bit 0 swaps byte pairs giving order 1,0,3,2
// - four enable bits gate rx0, rx1, tx0, tx1; clear resets that channel
// - per-channel lsb-first bit serialises lsb first, else msb first
`timescale 1ns/1ps

module bcr_regs
  import bcr_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire bcr_pkg::bcr_bus_s      bus,
  output logic [bcr_pkg::DATA_W-1:0]  rdata,
  input  wire logic                   local_transfer_clock_locked,
  input  wire logic                   remote_transfer_clock_locked,
  input  wire logic                   fifo_overflow,
  input  wire logic                   fifo_underflow,
  input  wire logic [bcr_pkg::WORD_W-1:0] word_in,
  output logic [bcr_pkg::WORD_W-1:0]  word_out,
  input  wire logic [1:0]             word_chan,
  output bcr_pkg::bcr_ctrl_s          ctrl,
  output logic                        irq
);
  import bcr_pkg::*;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // lock bits flag any change, fifo flags only their rising edge
  function automatic logic level_moved(input logic now_v, input logic was_v);
    level_moved = now_v ^ was_v;
  endfunction

  function automatic logic level_rose(input logic now_v, input logic was_v);
    level_rose = now_v & ~was_v;
  endfunction

  function automatic logic [WORD_W-1:0] swap_byte_pairs(input logic [WORD_W-1:0] w);
    swap_byte_pairs = {w[23:16], w[31:24], w[7:0], w[15:8]};
  endfunction

  function automatic logic [WORD_W-1:0] swap_halves(input logic [WORD_W-1:0] w);
    swap_halves = {w[15:0], w[31:16]};
  endfunction

  function automatic logic [WORD_W-1:0] mirror_bits(input logic [WORD_W-1:0] w);
    mirror_bits = {<<{w}};
  endfunction

  // byte pairs first, then halves, then the mirror for lsb-first channels
  function automatic logic [WORD_W-1:0] reorder(input logic [WORD_W-1:0] w,
                                                input logic bsw,
                                                input logic hsw,
                                                input logic lsb);
    logic [WORD_W-1:0] t;
    t = w;
    if (bsw) begin
      t = swap_byte_pairs(t);
    end
    if (hsw) begin
      t = swap_halves(t);
    end
    // position 31 leaves the serialiser first, so lsb-first mirrors the word
    if (lsb) begin
      t = mirror_bits(t);
    end
    reorder = t;
  endfunction

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [IRQ_W-1:0] sync1;
  logic [IRQ_W-1:0] sync2;
  logic [IRQ_W-1:0] sync_d;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1  <= '0;
      sync2  <= '0;
      sync_d <= '0;
    end else begin
      sync1  <= {fifo_underflow, fifo_overflow,
                 remote_transfer_clock_locked, local_transfer_clock_locked};
      sync2  <= sync1;
      sync_d <= sync2;
    end
  end

  // ------------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------------
  logic             cmd_enable;
  logic [7:0]       word_order_config;
  logic [NCH-1:0]   channel_enable_bits;
  logic [NCH-1:0]   lsb_first;
  logic [IRQ_W-1:0] irq_mask;

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  // no decode for the lock status: it is read only, writes fall away
  logic wr_cmd;
  logic wr_cfg;
  logic wr_chen;
  logic wr_lsb;
  logic wr_mask;
  logic wr_status;

  always_comb begin
    wr_cmd    = bus.wr && hit(bus.addr, OFF_GLOBAL_COMMAND);
    wr_cfg    = bus.wr && hit(bus.addr, OFF_WORD_ORDER_CONFIG);
    wr_chen   = bus.wr && hit(bus.addr, OFF_CHANNEL_ENABLE);
    wr_lsb    = bus.wr && hit(bus.addr, OFF_LSB_FIRST);
    wr_mask   = bus.wr && hit(bus.addr, OFF_IRQ_MASK);
    wr_status = bus.wr && hit(bus.addr, OFF_IRQ_STATUS);
  end

  // only the enable bit is kept, the rest of the byte reads zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_enable <= 1'b0;
    end else if (wr_cmd) begin
      cmd_enable <= bus.wdata[BIT_CMD_ENABLE];
    end
  end

  // unused config bits are dropped on write so they read back zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      word_order_config <= RST_REG;
    end else if (wr_cfg) begin
      word_order_config                     <= RST_REG;
      word_order_config[BIT_HALF_WORD_SWAP] <= bus.wdata[BIT_HALF_WORD_SWAP];
      word_order_config[BIT_BYTE_PAIR_SWAP] <= bus.wdata[BIT_BYTE_PAIR_SWAP];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      channel_enable_bits <= '0;
    end else if (wr_chen) begin
      channel_enable_bits <= bus.wdata[NCH-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lsb_first <= '0;
    end else if (wr_lsb) begin
      lsb_first <= bus.wdata[NCH-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= '0;
    end else if (wr_mask) begin
      irq_mask <= bus.wdata[IRQ_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // channel control outputs
  // ------------------------------------------------------------------
  bcr_ctrl_s           next_ctrl;
  wire logic [NCH-1:0] chan_live;

  // one gate per channel: a channel runs only with both enables set
  for (genvar gc = 0; gc < NCH; gc++) begin : g_chan
    assign chan_live[gc] = channel_enable_bits[gc] & cmd_enable;
  end

  always_comb begin
    next_ctrl            = '0;
    next_ctrl.dma_allow  = chan_live;
    next_ctrl.chan_reset = ~chan_live;
    next_ctrl.fifo_flush = ~cmd_enable;
    next_ctrl.flag_clear = ~cmd_enable;
  end

  // reset holds every channel in reset and the fifos flushed
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= '{dma_allow: '0, chan_reset: '1, fifo_flush: 1'b1, flag_clear: 1'b1};
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ------------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] flow_keep;
  logic [IRQ_W-1:0] next_irq_status;

  // events come from the second sync stage against its delayed copy
  always_comb begin
    events               = '0;
    events[IRQ_LOCAL]    = level_moved(sync2[IRQ_LOCAL], sync_d[IRQ_LOCAL]);
    events[IRQ_REMOTE]   = level_moved(sync2[IRQ_REMOTE], sync_d[IRQ_REMOTE]);
    events[IRQ_OVERFLOW] = level_rose(sync2[IRQ_OVERFLOW], sync_d[IRQ_OVERFLOW]);
    events[IRQ_UNDERFL]  = level_rose(sync2[IRQ_UNDERFL], sync_d[IRQ_UNDERFL]);
  end

  always_comb begin
    clr = '0;
    if (wr_status) begin
      clr = bus.wdata[IRQ_W-1:0];
    end
  end

  // flow bits may not stand while the command enable is clear
  always_comb begin
    flow_keep               = '1;
    flow_keep[IRQ_OVERFLOW] = cmd_enable;
    flow_keep[IRQ_UNDERFL]  = cmd_enable;
  end

  // set wins over a write-one clear in the same cycle
  always_comb begin
    next_irq_status = ((irq_status & ~clr) | events) & flow_keep;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // irq follows the status it will hold, so both change on one edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  logic [7:0] next_rdata;
  logic [7:0] cmd_view;
  logic [7:0] lock_view;
  logic [7:0] chen_view;
  logic [7:0] lsb_view;
  logic [7:0] status_view;
  logic [7:0] mask_view;

  // unused bits of every register read zero
  always_comb begin
    cmd_view                   = RD_UNMAP;
    cmd_view[BIT_CMD_ENABLE]   = cmd_enable;
    lock_view                  = RD_UNMAP;
    lock_view[BIT_REMOTE_LOCK] = sync2[IRQ_REMOTE];
    lock_view[BIT_LOCAL_LOCK]  = sync2[IRQ_LOCAL];
    chen_view                  = RD_UNMAP;
    chen_view[NCH-1:0]         = channel_enable_bits;
    lsb_view                   = RD_UNMAP;
    lsb_view[NCH-1:0]          = lsb_first;
    status_view                = RD_UNMAP;
    status_view[IRQ_W-1:0]     = irq_status;
    mask_view                  = RD_UNMAP;
    mask_view[IRQ_W-1:0]       = irq_mask;
  end

  // an idle port reads zero, so read data stand only after a read
  always_comb begin
    next_rdata = RD_UNMAP;
    if (bus.rd) begin
      case (bus.addr)
        OFF_GLOBAL_COMMAND:    next_rdata = cmd_view;
        OFF_CLOCK_LOCK_STATUS: next_rdata = lock_view;
        OFF_WORD_ORDER_CONFIG: next_rdata = word_order_config;
        OFF_CHANNEL_ENABLE:    next_rdata = chen_view;
        OFF_LSB_FIRST:         next_rdata = lsb_view;
        OFF_IRQ_STATUS:        next_rdata = status_view;
        OFF_IRQ_MASK:          next_rdata = mask_view;
        default:               next_rdata = RD_UNMAP;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= RD_UNMAP;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // data word ordering
  // ------------------------------------------------------------------
  // one register stage; input half one is bits 0..15, half two 16..31
  logic [WORD_W-1:0] next_word;
  logic              chan_lsb_first;

  // the channel index picks which lsb-first bit applies to this word
  always_comb begin
    chan_lsb_first = lsb_first[word_chan];
    next_word      = reorder(word_in,
                             word_order_config[BIT_BYTE_PAIR_SWAP],
                             word_order_config[BIT_HALF_WORD_SWAP],
                             chan_lsb_first);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      word_out <= '0;
    end else begin
      word_out <= next_word;
    end
  end

endmodule
